//--- src/pmd_defines.vh
// Offsets, field positions, reset values and masks of the module-off block.
`ifndef PMD_DEFINES_VH
`define PMD_DEFINES_VH

`define PMD_ADDR_W          4
`define PMD_OFF_LOCK_CTRL   4'h0
`define PMD_OFF_REG_ONE     4'h1
`define PMD_OFF_REG_TWO     4'h2
`define PMD_OFF_REG_THREE   4'h3
`define PMD_OFF_REG_FOUR    4'h4
`define PMD_OFF_REG_FIVE    4'h5
`define PMD_OFF_UNLOCK      4'h6
`define PMD_OFF_STATUS      4'h7

`define PMD_LOCK_BIT        11
`define PMD_LOCK_RESET      1'b0
`define PMD_OFF_RESET       32'h0000_0000

`define PMD_MASK_ONE        32'h0010_1001
`define PMD_MASK_TWO        32'h0f00_0007
`define PMD_MASK_THREE      32'h0001_ff00
`define PMD_MASK_FOUR       32'h0000_0007
`define PMD_MASK_FIVE       32'h0000_0001

`define PMD_CONV_BIT        0
`define PMD_VREF_BIT        12
`define PMD_VDET_BIT        20
`define PMD_CMP_LSB         0
`define PMD_CLC_LSB         24
`define PMD_CCP_LSB         8
`define PMD_TMR_LSB         0
`define PMD_UART_BIT        0

`define PMD_KEY_ONE         32'haa99_6655
`define PMD_KEY_TWO         32'h5566_99aa

`endif

//--- src/pmd_unlock_seq.v
// Two-word unlock sequence detector that opens the lock-change window.
`timescale 1ns/1ps
`default_nettype none
`include "pmd_defines.vh"

module pmd_unlock_seq
(
    input  wire        sys_clk,
    input  wire        resetn,
    input  wire        key_we,
    input  wire [31:0] key_data,
    input  wire        relock,
    output reg         unlocked_reg
);
    localparam ST_IDLE = 2'h0;
    localparam ST_KEY1 = 2'h1;
    localparam ST_OPEN = 2'h2;

    reg [1:0] state_reg;
    reg [1:0] state_next;

    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (key_we && key_data == `PMD_KEY_ONE)
                    state_next = ST_KEY1;
            end
            ST_KEY1:
            begin
                if (key_we)
                    state_next = (key_data == `PMD_KEY_TWO) ? ST_OPEN
                                                            : ST_IDLE;
            end
            ST_OPEN:
            begin
                // Any further key write or a relock closes the window.
                if (relock || key_we)
                    state_next = ST_IDLE;
            end
            default:
                state_next = ST_IDLE;
        endcase
    end

    always @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            state_reg    <= ST_IDLE;
            unlocked_reg <= 1'b0;
        end
        else
        begin
            state_reg    <= state_next;
            unlocked_reg <= (state_next == ST_OPEN);
        end
    end
endmodule // pmd_unlock_seq
`default_nettype wire

//--- src/pmd_module_off.v
// Peripheral module-off registers, lock and per-peripheral clock enables.
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pmd_defines.vh"

// Summary of operation
// - A set off bit stops every clock feeding that peripheral.
// - Disabled peripheral register write strobes are dropped and read valids are held low.
// - Writing one disables a peripheral; zero leaves it running.
// - All off bits reset to zero, so peripherals start enabled.
// - Locked writes to off registers complete normally but change nothing.
// - Lock bit 11 of the control register blocks off-register writes.
// - Register one: converter bit 0, reference bit 12, detect bit 20.
// - Register two: comparators bits 0-2, logic cells bits 24-27.
// - Register three: capture units one to nine at bits 8-16.
// - Register four: timers bits 0-2; register five: serial port bit 0.
module pmd_module_off
#(
    parameter NUM_PERIPH = 23
)
(
    input  wire                   sys_clk,
    input  wire                   resetn,
    input  wire [`PMD_ADDR_W-1:0] addr,
    input  wire [31:0]            wdata,
    input  wire                   wr_stb,
    input  wire                   rd_stb,
    output reg  [31:0]            rdata,
    input  wire [NUM_PERIPH-1:0]  periph_clk_in,
    output reg  [NUM_PERIPH-1:0]  periph_clk_en,
    input  wire [NUM_PERIPH-1:0]  periph_wr_stb,
    output reg  [NUM_PERIPH-1:0]  periph_wr_ok,
    input  wire [NUM_PERIPH-1:0]  periph_rd_valid,
    output reg  [NUM_PERIPH-1:0]  periph_rd_ok,
    output reg                    converter_off,
    output reg                    voltage_ref_off,
    output reg                    voltage_detect_off,
    output reg  [2:0]             comparator_off,
    output reg  [3:0]             logic_cell_off,
    output reg  [8:0]             capture_unit_off,
    output reg  [2:0]             timer_off,
    output reg                    serial_port_one_off
);
    reg  [31:0]           off_reg_one_reg;
    reg  [31:0]           off_reg_two_reg;
    reg  [31:0]           off_reg_three_reg;
    reg  [31:0]           off_reg_four_reg;
    reg  [31:0]           off_reg_five_reg;
    reg                   off_bits_lock_reg;
    reg  [NUM_PERIPH-1:0] module_off_bit;
    wire                  unlocked;
    wire                  key_we;

    // Decodes whether a bus write targets a given register.
    function wr_hit;
        input [`PMD_ADDR_W-1:0] a;
        input [`PMD_ADDR_W-1:0] target;
        begin
            wr_hit = (a == target);
        end
    endfunction

    assign key_we = wr_stb && wr_hit(addr, `PMD_OFF_UNLOCK);

    pmd_unlock_seq pmd_unlock_seq_inst
    (
        .sys_clk      (sys_clk),
        .resetn       (resetn),
        .key_we       (key_we),
        .key_data     (wdata),
        .relock       (wr_stb && wr_hit(addr, `PMD_OFF_LOCK_CTRL)),
        .unlocked_reg (unlocked)
    );

    // Flatten the sparse register bits into one peripheral-order vector.
    always @*
    begin
        module_off_bit = {NUM_PERIPH{1'b0}};
        module_off_bit[0]     = off_reg_one_reg[`PMD_CONV_BIT];
        module_off_bit[1]     = off_reg_one_reg[`PMD_VREF_BIT];
        module_off_bit[2]     = off_reg_one_reg[`PMD_VDET_BIT];
        module_off_bit[5:3]   = off_reg_two_reg[`PMD_CMP_LSB +: 3];
        module_off_bit[9:6]   = off_reg_two_reg[`PMD_CLC_LSB +: 4];
        module_off_bit[18:10] = off_reg_three_reg[`PMD_CCP_LSB +: 9];
        module_off_bit[21:19] = off_reg_four_reg[`PMD_TMR_LSB +: 3];
        module_off_bit[22]    = off_reg_five_reg[`PMD_UART_BIT];
    end

    always @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            off_reg_one_reg   <= `PMD_OFF_RESET;
            off_reg_two_reg   <= `PMD_OFF_RESET;
            off_reg_three_reg <= `PMD_OFF_RESET;
            off_reg_four_reg  <= `PMD_OFF_RESET;
            off_reg_five_reg  <= `PMD_OFF_RESET;
            off_bits_lock_reg <= `PMD_LOCK_RESET;
        end
        else if (wr_stb)
        begin
            // Lock only moves inside the unlock window.
            if (wr_hit(addr, `PMD_OFF_LOCK_CTRL) && unlocked)
                off_bits_lock_reg <= wdata[`PMD_LOCK_BIT];
            // Locked writes are accepted silently.
            if (!off_bits_lock_reg)
            begin
                if (wr_hit(addr, `PMD_OFF_REG_ONE))
                    off_reg_one_reg <= wdata & `PMD_MASK_ONE;
                if (wr_hit(addr, `PMD_OFF_REG_TWO))
                    off_reg_two_reg <= wdata & `PMD_MASK_TWO;
                if (wr_hit(addr, `PMD_OFF_REG_THREE))
                    off_reg_three_reg <= wdata & `PMD_MASK_THREE;
                if (wr_hit(addr, `PMD_OFF_REG_FOUR))
                    off_reg_four_reg <= wdata & `PMD_MASK_FOUR;
                if (wr_hit(addr, `PMD_OFF_REG_FIVE))
                    off_reg_five_reg <= wdata & `PMD_MASK_FIVE;
            end
        end
    end

    // Read data appears the cycle after the strobe and is zero otherwise.
    always @(posedge sys_clk)
    begin
        if (!resetn)
            rdata <= 32'h0000_0000;
        else if (rd_stb)
        begin
            case (addr)
                `PMD_OFF_LOCK_CTRL:
                    rdata <= {20'h00000, off_bits_lock_reg, 11'h000};
                `PMD_OFF_REG_ONE:   rdata <= off_reg_one_reg;
                `PMD_OFF_REG_TWO:   rdata <= off_reg_two_reg;
                `PMD_OFF_REG_THREE: rdata <= off_reg_three_reg;
                `PMD_OFF_REG_FOUR:  rdata <= off_reg_four_reg;
                `PMD_OFF_REG_FIVE:  rdata <= off_reg_five_reg;
                `PMD_OFF_STATUS:    rdata <= {31'h0, unlocked};
                default:            rdata <= 32'h0000_0000;
            endcase
        end
        else
            rdata <= 32'h0000_0000;
    end

    // Enables are registered so the downstream gate cells see a glitch-free
    // level; the gate itself belongs in the clock tree, not in this logic.
    genvar i;
    generate
        for (i = 0; i < NUM_PERIPH; i = i + 1)
        begin : g_gate
            always @(posedge sys_clk)
            begin
                if (!resetn)
                begin
                    periph_clk_en[i] <= 1'b1;
                    periph_wr_ok[i]  <= 1'b0;
                    periph_rd_ok[i]  <= 1'b0;
                end
                else
                begin
                    periph_clk_en[i] <= ~module_off_bit[i];
                    periph_wr_ok[i]  <= periph_wr_stb[i]
                                        & ~module_off_bit[i];
                    periph_rd_ok[i]  <= periph_rd_valid[i]
                                        & ~module_off_bit[i];
                end
            end
        end
    endgenerate

    always @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            converter_off       <= 1'b0;
            voltage_ref_off     <= 1'b0;
            voltage_detect_off  <= 1'b0;
            comparator_off      <= 3'h0;
            logic_cell_off      <= 4'h0;
            capture_unit_off    <= 9'h000;
            timer_off           <= 3'h0;
            serial_port_one_off <= 1'b0;
        end
        else
        begin
            converter_off       <= module_off_bit[0];
            voltage_ref_off     <= module_off_bit[1];
            voltage_detect_off  <= module_off_bit[2];
            comparator_off      <= module_off_bit[5:3];
            logic_cell_off      <= module_off_bit[9:6];
            capture_unit_off    <= module_off_bit[18:10];
            timer_off           <= module_off_bit[21:19];
            serial_port_one_off <= module_off_bit[22];
        end
    end

    // The raw peripheral clocks are passed in only so the gate owner can
    // see them in one place; this block never clocks on them.
    wire unused_clks = |periph_clk_in;
endmodule // pmd_module_off
`default_nettype wire

//--- tb/pmd_module_off_monitor.sv
// Port-level checker of the module-off block, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
`include "pmd_defines.vh"
module pmd_module_off_monitor
#(
    parameter NUM_PERIPH = 23
)
(
    input wire logic                   sys_clk,
    input wire logic                   resetn,
    input wire logic [`PMD_ADDR_W-1:0] addr,
    input wire logic                   wr_stb,
    input wire logic                   rd_stb,
    input wire logic [31:0]            rdata,
    input wire logic [NUM_PERIPH-1:0]  periph_clk_en,
    input wire logic [NUM_PERIPH-1:0]  periph_wr_stb,
    input wire logic [NUM_PERIPH-1:0]  periph_wr_ok,
    input wire logic [NUM_PERIPH-1:0]  periph_rd_valid,
    input wire logic [NUM_PERIPH-1:0]  periph_rd_ok,
    input wire logic                   converter_off,
    input wire logic [2:0]             timer_off,
    input wire logic                   serial_port_one_off
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    AST_CLK_GATE: assert property (periph_clk_en[0] == !converter_off
        && periph_clk_en[21:19] == ~timer_off
        && periph_clk_en[22] == !serial_port_one_off)
        else $error("clock enable disagrees with off bits");
    // The gate is only judged once the off bits have settled on both sides.
    AST_WR_GATE: assert property ($stable(periph_clk_en) ##1
        $stable(periph_clk_en) |->
        periph_wr_ok == ($past(periph_wr_stb) & periph_clk_en))
        else $error("write pass-through wrong");
    AST_RD_GATE: assert property ($stable(periph_clk_en) ##1
        $stable(periph_clk_en) |->
        periph_rd_ok == ($past(periph_rd_valid) & periph_clk_en))
        else $error("read pass-through wrong");
    AST_RDATA_IDLE: assert property (rdata != 32'h0 |-> $past(rd_stb))
        else $error("read data outside its cycle");
    AST_MASK_ONE: assert property (rd_stb && addr == `PMD_OFF_REG_ONE
        |=> (rdata & ~`PMD_MASK_ONE) == 32'h0)
        else $error("unimplemented bit set in register one");
    AST_MASK_THREE: assert property (rd_stb && addr == `PMD_OFF_REG_THREE
        |=> (rdata & ~`PMD_MASK_THREE) == 32'h0)
        else $error("unimplemented bit set in register three");
    AST_CONV_CAUSE: assert property (!$stable(converter_off) |->
        $past(wr_stb, 2) && $past(addr, 2) == `PMD_OFF_REG_ONE)
        else $error("converter off bit moved without a write");
    AST_UART_CAUSE: assert property (!$stable(serial_port_one_off) |->
        $past(wr_stb, 2) && $past(addr, 2) == `PMD_OFF_REG_FIVE)
        else $error("serial port off bit moved without a write");
    AST_RESET_STATE: assert property (disable iff (1'b0) !resetn |=>
        periph_clk_en == {NUM_PERIPH{1'b1}} && rdata == 32'h0)
        else $error("reset state wrong");

    cover property (wr_stb && addr == `PMD_OFF_LOCK_CTRL);
    cover property (|(periph_wr_stb & ~periph_clk_en));
    cover property ($rose(serial_port_one_off));
endmodule // pmd_module_off_monitor

bind pmd_module_off pmd_module_off_monitor #(.NUM_PERIPH(NUM_PERIPH)) mon_inst (
    .sys_clk(sys_clk), .resetn(resetn), .addr(addr), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .periph_clk_en(periph_clk_en),
    .periph_wr_stb(periph_wr_stb), .periph_wr_ok(periph_wr_ok),
    .periph_rd_valid(periph_rd_valid), .periph_rd_ok(periph_rd_ok),
    .converter_off(converter_off), .timer_off(timer_off),
    .serial_port_one_off(serial_port_one_off));
`default_nettype wire

//--- tb/pmd_module_off_tb.sv
// Self-checking bench of the module-off block.
`timescale 1ns/1ps
`default_nettype none
`include "pmd_defines.vh"
module pmd_module_off_tb;
    logic        sys_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr_stb = 1'b0;
    logic        rd_stb = 1'b0;
    logic [22:0] ck_in = 23'h0;
    logic [22:0] wr_in = 23'h0;
    logic [22:0] rd_in = 23'h0;
    logic [22:0] wr_q, rd_q, ck_en, wr_ok, rd_ok;
    logic [31:0] rdata, q;
    logic [31:0] model [1:5];
    logic        locked = 1'b0;
    logic        conv, vref, vdet, uart;
    logic [2:0]  cmp, tmr;
    logic [3:0]  clc;
    logic [8:0]  ccp;
    int          miscompares = 0;
    int          tests_run = 0;

    pmd_module_off #(.NUM_PERIPH(23)) pmd_module_off_inst (
        .sys_clk(sys_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .periph_clk_in(ck_in), .periph_clk_en(ck_en),
        .periph_wr_stb(wr_in), .periph_wr_ok(wr_ok),
        .periph_rd_valid(rd_in), .periph_rd_ok(rd_ok),
        .converter_off(conv), .voltage_ref_off(vref),
        .voltage_detect_off(vdet), .comparator_off(cmp),
        .logic_cell_off(clc), .capture_unit_off(ccp), .timer_off(tmr),
        .serial_port_one_off(uart));

    initial forever #5 sys_clk = ~sys_clk;

    always @(posedge sys_clk)
    begin
        ck_in <= 23'($urandom);
        wr_in <= 23'($urandom);
        rd_in <= 23'($urandom);
        wr_q <= wr_in;
        rd_q <= rd_in;
    end

    function automatic [31:0] msk(input [3:0] a);
        case (a)
            4'h1: msk = `PMD_MASK_ONE;
            4'h2: msk = `PMD_MASK_TWO;
            4'h3: msk = `PMD_MASK_THREE;
            4'h4: msk = `PMD_MASK_FOUR;
            4'h5: msk = `PMD_MASK_FIVE;
            default: msk = 32'h0;
        endcase
    endfunction

    function automatic [22:0] offv();
        offv = {model[5][0], model[4][2:0], model[3][16:8], model[2][27:24],
            model[2][2:0], model[1][20], model[1][12], model[1][0]};
    endfunction

    task automatic chk(input [31:0] got, input [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input [3:0] a, input [31:0] d);
        wr_stb <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
        @(posedge sys_clk);
        if (a >= 4'h1 && a <= 4'h5 && !locked)
            model[a] = d & msk(a);
    endtask

    task automatic rdc(input [3:0] a, input [31:0] exp);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1;
        chk(rdata, exp);
        @(posedge sys_clk);
    endtask

    // The outputs already follow the last write; one more edge and #1 give a settled point to check them.
    task automatic gates();
        @(posedge sys_clk);
        #1;
        chk({9'h0, ck_en}, {9'h0, ~offv()});
        chk({9'h0, uart, tmr, ccp, clc, cmp, vdet, vref, conv},
            {9'h0, offv()});
        chk({9'h0, wr_ok}, {9'h0, wr_q & ~offv()});
        chk({9'h0, rd_ok}, {9'h0, rd_q & ~offv()});
    endtask

    task automatic do_reset();
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        locked = 1'b0;
        for (int i = 1; i <= 5; i++)
            model[i] = 32'h0;
        @(posedge sys_clk);
    endtask

    task automatic give_verdict();
        $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        int a;
        q = $urandom(32'h5d1b);
        do_reset();
        for (a = 0; a < 9; a++)
            rdc(a[3:0], 32'h0);
        gates();
        $display("reset test done");
        for (a = 1; a <= 5; a++)
        begin
            wr(a[3:0], 32'hffff_ffff);
            rdc(a[3:0], msk(a[3:0]));
        end
        gates();
        repeat (40)
        begin
            a = 1 + ($urandom % 5);
            wr(a[3:0], $urandom);
            rdc(a[3:0], model[a]);
            gates();
        end
        $display("random test done");
        wr(4'h6, `PMD_KEY_ONE);
        wr(4'h6, `PMD_KEY_TWO);
        rdc(4'h7, 32'h1);
        wr(4'h0, 32'h0000_0800);
        locked = 1'b1;
        rdc(4'h7, 32'h0);
        wr(4'h1, ~model[1]);
        rdc(4'h1, model[1]);
        gates();
        wr(4'h0, 32'h0);
        rdc(4'h0, 32'h0000_0800);
        wr(4'h6, `PMD_KEY_ONE);
        wr(4'h6, 32'h1);
        wr(4'h0, 32'h0);
        rdc(4'h0, 32'h0000_0800);
        // A third key write closes an open window before the lock write.
        wr(4'h6, `PMD_KEY_ONE);
        wr(4'h6, `PMD_KEY_TWO);
        wr(4'h6, `PMD_KEY_TWO);
        rdc(4'h7, 32'h0);
        wr(4'h0, 32'h0);
        rdc(4'h0, 32'h0000_0800);
        wr(4'h6, `PMD_KEY_ONE);
        wr(4'h6, `PMD_KEY_TWO);
        wr(4'h0, 32'h0);
        locked = 1'b0;
        wr(4'h2, 32'hffff_ffff);
        rdc(4'h2, `PMD_MASK_TWO);
        $display("lock test done");
        do_reset();
        rdc(4'h2, 32'h0);
        gates();
        $display("second reset test done");
        give_verdict();
    end

    // The whole run needs about 300 cycles; this bound only catches a hang.
    initial
    begin
        #100000;
        miscompares++;
        $display("[ERR] %0t watchdog expired", $time);
        give_verdict();
    end
endmodule // pmd_module_off_tb
`default_nettype wire
